// file: include/cable_diag_pkg.sv
// Constants and types shared by the cable diagnostic peak result bank
package cable_diag_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned LOC_W = 8;
  localparam int unsigned AMP_W = 7;
  localparam int unsigned PEAK_CNT = 5;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned MIN_ADDR_W = 12;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_TX_LOC_1_2 = 10'h180;
  localparam logic [9:0] IDX_TX_LOC_3_4 = 10'h181;
  localparam logic [9:0] IDX_MIX_LOC_TX5_RX1 = 10'h182;
  localparam logic [9:0] IDX_RX_LOC_2_3 = 10'h183;
  localparam logic [9:0] IDX_RX_LOC_4_5 = 10'h184;
  localparam logic [9:0] IDX_TX_AMP_1_2 = 10'h185;
  localparam logic [9:0] IDX_TX_AMP_3_4 = 10'h186;
  localparam logic [9:0] IDX_MIX_AMP_TX5_RX1 = 10'h187;
  localparam logic [9:0] IDX_RESULT_CTRL = 10'h190;
  localparam logic [9:0] IDX_RESULT_STAT = 10'h191;
  // Field positions within a 16-bit result word
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_LSB = 0;
  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] LOC_RESET = 8'h00;
  localparam logic [6:0] AMP_RESET = 7'h00;
  localparam logic CAPTURE_EN_RESET = 1'h1;
  // Control and status bit positions
  localparam int unsigned CTRL_CAPTURE_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_DROP_BIT = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } apb_state_t;
endpackage

// file: include/reg_access_if.sv
// Register access carrier between the bus port and the result bank
`timescale 1ns/10ps
interface reg_access_if;
  logic [9:0] index;
  logic wr_en;
  logic [3:0] wr_strb;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;
  modport port (output index, output wr_en, output wr_strb, output wdata,
                input rdata, input hit);
  modport bank (input index, input wr_en, input wr_strb, input wdata,
                output rdata, output hit);
endinterface

// file: design/peak_field_reg.sv
// One result field held from load to load
`timescale 1ns/10ps
module peak_field_reg #(
  parameter int unsigned W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  if (W < 1 || W > 16) begin : g_bad_width
    $error("peak_field_reg: width out of range");
  end

  // Reads never touch the field; only a completed run or reset does
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '0;
    end else if (load) begin
      q <= d;
    end
  end
endmodule

// file: design/apb_reg_port.sv
// APB slave port with one access wait-free answer
`timescale 1ns/10ps
module apb_reg_port #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  reg_access_if.port bus
);
  cable_diag_pkg::apb_state_t state;
  logic upper_zero;
  logic mapped;

  if (ADDR_W < cable_diag_pkg::MIN_ADDR_W) begin : g_bad_addr
    $error("apb_reg_port: address too narrow for the register map");
  end

  assign upper_zero = (paddr >> (cable_diag_pkg::ADDR_LSB + cable_diag_pkg::IDX_W)) == '0;
  assign mapped = upper_zero && bus.hit;
  assign bus.index = paddr[cable_diag_pkg::ADDR_LSB +: cable_diag_pkg::IDX_W];
  assign bus.wdata = pwdata;
  assign bus.wr_strb = pstrb;
  // A write lands only on the completing edge of the access phase
  assign bus.wr_en = (state == cable_diag_pkg::ST_ANSWER) && psel && penable
                     && pwrite && mapped;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= cable_diag_pkg::ST_IDLE;
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h00000000;
    end else begin
      case (state)
        cable_diag_pkg::ST_IDLE: begin
          if (psel && !penable) begin
            state <= cable_diag_pkg::ST_ANSWER;
            pready <= 1'h1;
            pslverr <= !mapped;
            prdata <= (mapped && !pwrite) ? bus.rdata : 32'h00000000;
          end
        end
        cable_diag_pkg::ST_ANSWER: begin
          state <= cable_diag_pkg::ST_IDLE;
          pready <= 1'h0;
          pslverr <= 1'h0;
        end
        default: begin
          state <= cable_diag_pkg::ST_IDLE;
          pready <= 1'h0;
          pslverr <= 1'h0;
        end
      endcase
    end
  end
endmodule

// file: design/cable_diag_peak_results.sv
// Cable diagnostic peak location and amplitude result bank on APB
`timescale 1ns/10ps
module cable_diag_peak_results #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned PEAKS = 5
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RUN_START,
  input wire logic RESULT_LOAD,
  input wire logic [PEAKS*8-1:0] TX_PEAK_LOC,
  input wire logic [PEAKS*8-1:0] RX_PEAK_LOC,
  input wire logic [PEAKS*7-1:0] TX_PEAK_AMP,
  input wire logic [6:0] RX_PEAK_AMP_1,
  output logic DIAG_DONE
);
  localparam int unsigned LW = cable_diag_pkg::LOC_W;
  localparam int unsigned AW = cable_diag_pkg::AMP_W;

  reg_access_if bus ();

  logic capture_en;
  logic busy;
  logic dropped;
  logic field_load;
  logic [LW-1:0] tx_loc [PEAKS];
  logic [LW-1:0] rx_loc [PEAKS];
  logic [AW-1:0] tx_amp [PEAKS];
  logic [AW-1:0] rx_amp_1;
  logic [15:0] next_rdata;
  logic next_hit;
  logic ctrl_write;
  logic stat_write;

  if (PEAKS != cable_diag_pkg::PEAK_CNT) begin : g_bad_peaks
    $error("cable_diag_peak_results: the map holds exactly five peaks per pair");
  end

  // Location word: two 8-bit distances side by side
  function automatic logic [15:0] pack_loc(input logic [7:0] hi, input logic [7:0] lo);
    pack_loc = {hi, lo};
  endfunction

  // Amplitude word: reserved bits above each 7-bit field forced low
  function automatic logic [15:0] pack_amp(input logic [6:0] hi, input logic [6:0] lo);
    pack_amp = {1'h0, hi, 1'h0, lo};
  endfunction

  apb_reg_port #(
    .ADDR_W(ADDR_W)
  ) u_port (
    .clock(CLOCK),
    .resetn(RESETN),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pstrb(PSTRB),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .bus(bus.port)
  );

  // Capture can be frozen by software so a good result survives later runs
  assign field_load = RESULT_LOAD && capture_en;

  // Transmit-pair locations, peak 1 in the lowest byte
  peak_field_reg #(
    .W(LW)
  ) u_tx_loc_1 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_LOC[0*LW +: LW]),
    .q(tx_loc[0])
  );

  peak_field_reg #(
    .W(LW)
  ) u_tx_loc_2 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_LOC[1*LW +: LW]),
    .q(tx_loc[1])
  );

  peak_field_reg #(
    .W(LW)
  ) u_tx_loc_3 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_LOC[2*LW +: LW]),
    .q(tx_loc[2])
  );

  peak_field_reg #(
    .W(LW)
  ) u_tx_loc_4 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_LOC[3*LW +: LW]),
    .q(tx_loc[3])
  );

  peak_field_reg #(
    .W(LW)
  ) u_tx_loc_5 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_LOC[4*LW +: LW]),
    .q(tx_loc[4])
  );

  // Receive-pair locations
  peak_field_reg #(
    .W(LW)
  ) u_rx_loc_1 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(RX_PEAK_LOC[0*LW +: LW]),
    .q(rx_loc[0])
  );

  peak_field_reg #(
    .W(LW)
  ) u_rx_loc_2 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(RX_PEAK_LOC[1*LW +: LW]),
    .q(rx_loc[1])
  );

  peak_field_reg #(
    .W(LW)
  ) u_rx_loc_3 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(RX_PEAK_LOC[2*LW +: LW]),
    .q(rx_loc[2])
  );

  peak_field_reg #(
    .W(LW)
  ) u_rx_loc_4 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(RX_PEAK_LOC[3*LW +: LW]),
    .q(rx_loc[3])
  );

  peak_field_reg #(
    .W(LW)
  ) u_rx_loc_5 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(RX_PEAK_LOC[4*LW +: LW]),
    .q(rx_loc[4])
  );

  // Transmit-pair amplitudes, then receive-pair amplitude 1
  peak_field_reg #(
    .W(AW)
  ) u_tx_amp_1 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_AMP[0*AW +: AW]),
    .q(tx_amp[0])
  );

  peak_field_reg #(
    .W(AW)
  ) u_tx_amp_2 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_AMP[1*AW +: AW]),
    .q(tx_amp[1])
  );

  peak_field_reg #(
    .W(AW)
  ) u_tx_amp_3 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_AMP[2*AW +: AW]),
    .q(tx_amp[2])
  );

  peak_field_reg #(
    .W(AW)
  ) u_tx_amp_4 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_AMP[3*AW +: AW]),
    .q(tx_amp[3])
  );

  peak_field_reg #(
    .W(AW)
  ) u_tx_amp_5 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(TX_PEAK_AMP[4*AW +: AW]),
    .q(tx_amp[4])
  );

  peak_field_reg #(
    .W(AW)
  ) u_rx_amp_1 (
    .clock(CLOCK),
    .resetn(RESETN),
    .load(field_load),
    .d(RX_PEAK_AMP_1),
    .q(rx_amp_1)
  );

  assign ctrl_write = bus.wr_en && bus.wr_strb[0]
                      && (bus.index == cable_diag_pkg::IDX_RESULT_CTRL);
  assign stat_write = bus.wr_en && bus.wr_strb[0]
                      && (bus.index == cable_diag_pkg::IDX_RESULT_STAT);

  // Software control of result capture
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      capture_en <= cable_diag_pkg::CAPTURE_EN_RESET;
    end else if (ctrl_write) begin
      capture_en <= bus.wdata[cable_diag_pkg::CTRL_CAPTURE_BIT];
    end
  end

  // Run in progress: from start until the engine hands over results
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      busy <= 1'h0;
    end else if (RUN_START) begin
      busy <= 1'h1;
    end else if (RESULT_LOAD) begin
      busy <= 1'h0;
    end
  end

  // Done rises with a load while capture is on; a start in the same cycle does not hide it
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      DIAG_DONE <= 1'h0;
    end else if (field_load) begin
      DIAG_DONE <= 1'h1;
    end else if (RUN_START) begin
      DIAG_DONE <= 1'h0;
    end
  end

  // Sticky: a finished run was discarded because capture was off
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      dropped <= 1'h0;
    end else if (RESULT_LOAD && !capture_en) begin
      dropped <= 1'h1;
    end else if (stat_write && bus.wdata[cable_diag_pkg::STAT_DROP_BIT]) begin
      dropped <= 1'h0;
    end
  end

  // Read decode; reads have no side effects
  always_comb begin
    next_rdata = cable_diag_pkg::RESULT_RESET;
    next_hit = 1'h1;
    case (bus.index)
      cable_diag_pkg::IDX_TX_LOC_1_2: begin
        next_rdata = pack_loc(tx_loc[1], tx_loc[0]);
      end
      cable_diag_pkg::IDX_TX_LOC_3_4: begin
        next_rdata = pack_loc(tx_loc[3], tx_loc[2]);
      end
      cable_diag_pkg::IDX_MIX_LOC_TX5_RX1: begin
        next_rdata = pack_loc(rx_loc[0], tx_loc[4]);
      end
      cable_diag_pkg::IDX_RX_LOC_2_3: begin
        next_rdata = pack_loc(rx_loc[2], rx_loc[1]);
      end
      cable_diag_pkg::IDX_RX_LOC_4_5: begin
        next_rdata = pack_loc(rx_loc[4], rx_loc[3]);
      end
      cable_diag_pkg::IDX_TX_AMP_1_2: begin
        next_rdata = pack_amp(tx_amp[1], tx_amp[0]);
      end
      cable_diag_pkg::IDX_TX_AMP_3_4: begin
        next_rdata = pack_amp(tx_amp[3], tx_amp[2]);
      end
      cable_diag_pkg::IDX_MIX_AMP_TX5_RX1: begin
        next_rdata = pack_amp(rx_amp_1, tx_amp[4]);
      end
      cable_diag_pkg::IDX_RESULT_CTRL: begin
        next_rdata[cable_diag_pkg::CTRL_CAPTURE_BIT] = capture_en;
      end
      cable_diag_pkg::IDX_RESULT_STAT: begin
        next_rdata[cable_diag_pkg::STAT_BUSY_BIT] = busy;
        next_rdata[cable_diag_pkg::STAT_DONE_BIT] = DIAG_DONE;
        next_rdata[cable_diag_pkg::STAT_DROP_BIT] = dropped;
      end
      default: begin
        next_hit = 1'h0;
      end
    endcase
  end

  // Writes to result words are accepted on the bus and have no effect
  assign bus.rdata = {16'h0000, next_rdata};
  assign bus.hit = next_hit;
endmodule

// file: dv/cable_diag_peak_results_props.sv
// Port-level checks for the peak result bank
`timescale 1ns/10ps
module cable_diag_peak_results_props #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned PEAKS = 5
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RUN_START,
  input wire logic RESULT_LOAD,
  input wire logic [PEAKS*8-1:0] TX_PEAK_LOC,
  input wire logic [PEAKS*8-1:0] RX_PEAK_LOC,
  input wire logic [PEAKS*7-1:0] TX_PEAK_AMP,
  input wire logic [6:0] RX_PEAK_AMP_1,
  input wire logic DIAG_DONE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  amp_reserved_a: assert property (
    PREADY && !PWRITE && PADDR[11:2] inside {10'h185, 10'h186, 10'h187}
    |-> PRDATA[15] == 1'b0 && PRDATA[7] == 1'b0) else $error("reserved amp bit set");
  upper_zero_a: assert property (
    PREADY |-> PRDATA[31:16] == 16'h0000) else $error("upper read half not zero");
  done_cause_a: assert property (
    $rose(DIAG_DONE) |-> $past(RESULT_LOAD)) else $error("done without load");
  done_clear_a: assert property (
    RUN_START && !RESULT_LOAD |=> !DIAG_DONE) else $error("done kept over start");
  done_hold_a: assert property (
    DIAG_DONE && !RUN_START |=> DIAG_DONE) else $error("done dropped alone");
  ready_answer_a: assert property (
    PSEL && !PENABLE |=> PREADY) else $error("no answer after setup");
  ready_pulse_a: assert property (
    PREADY |=> !PREADY) else $error("ready longer than one cycle");
  ro_write_ok_a: assert property (
    PSEL && !PENABLE && PWRITE && PADDR[11:2] inside {[10'h180:10'h187]}
    |=> PREADY && !PSLVERR) else $error("result write refused");
  unmapped_err_a: assert property (
    PSEL && !PENABLE && !(PADDR[11:2] inside {[10'h180:10'h187], 10'h190, 10'h191})
    |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
endmodule

bind cable_diag_peak_results cable_diag_peak_results_props #(
  .ADDR_W(ADDR_W),
  .PEAKS(PEAKS)
) u_props (.*);

// file: dv/tb.sv
// Self-checking bench for the peak result bank
`timescale 1ns/10ps
module tb;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [3:0] PSTRB = 4'hF;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic [31:0] rd;
  logic PREADY, PSLVERR, DIAG_DONE, err;
  logic RUN_START = 1'b0;
  logic RESULT_LOAD = 1'b0;
  logic [39:0] TX_PEAK_LOC = 40'h5544332211;
  logic [39:0] RX_PEAK_LOC = 40'hAA99887766;
  // Amp 1 all ones, so a leak into reserved bit 7 would show
  logic [34:0] TX_PEAK_AMP = {7'h45, 7'h34, 7'h23, 7'h12, 7'h7F};
  logic [6:0] RX_PEAK_AMP_1 = 7'h56;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  // Index in [25:16], expected word in [15:0]
  logic [25:0] rows [8] = '{
    {10'h180, 16'h2211},
    {10'h181, 16'h4433},
    {10'h182, 16'h6655},
    {10'h183, 16'h8877},
    {10'h184, 16'hAA99},
    {10'h185, 16'h127F},
    {10'h186, 16'h3423},
    {10'h187, 16'h5645}
  };

  cable_diag_peak_results u_dut (.*);

  always #4 CLOCK = ~CLOCK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] wd);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {ix, 2'b00};
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic pulse(input logic start, input logic load);
    RUN_START <= start;
    RESULT_LOAD <= load;
    @(posedge CLOCK);
    RUN_START <= 1'b0;
    RESULT_LOAD <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // A hang ends the run well past the hundred or so cycles needed
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, rows[i][25:16], 32'h0);
      chk(rd, 32'h0);
    end
    chk(DIAG_DONE, 1'b0);
    pulse(1'b1, 1'b0);
    apb(1'b0, cable_diag_pkg::IDX_RESULT_STAT, 32'h0);
    chk(rd, 32'h1);
    pulse(1'b0, 1'b1);
    chk(DIAG_DONE, 1'b1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, rows[i][25:16], 32'h0);
      chk({err, rd[30:0]}, {16'h0, rows[i][15:0]});
    end
    // Result words accept a write and keep their value
    apb(1'b1, cable_diag_pkg::IDX_RX_LOC_4_5, 32'hFFFF);
    chk(err, 1'b0);
    apb(1'b0, cable_diag_pkg::IDX_RX_LOC_4_5, 32'h0);
    chk(rd, 32'hAA99);
    apb(1'b1, cable_diag_pkg::IDX_MIX_AMP_TX5_RX1, 32'hFFFF);
    apb(1'b0, cable_diag_pkg::IDX_MIX_AMP_TX5_RX1, 32'h0);
    chk(rd, 32'h5645);
    apb(1'b0, 10'h1A0, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    // A control write with lane 0 off is ignored
    PSTRB <= 4'hE;
    apb(1'b1, cable_diag_pkg::IDX_RESULT_CTRL, 32'h0);
    PSTRB <= 4'hF;
    apb(1'b0, cable_diag_pkg::IDX_RESULT_CTRL, 32'h0);
    chk(rd, 32'h1);
    // Load while capture is off must be dropped
    apb(1'b1, cable_diag_pkg::IDX_RESULT_CTRL, 32'h0);
    TX_PEAK_LOC <= 40'h0;
    pulse(1'b0, 1'b1);
    apb(1'b0, cable_diag_pkg::IDX_TX_LOC_1_2, 32'h0);
    chk(rd, 32'h2211);
    apb(1'b0, cable_diag_pkg::IDX_RESULT_STAT, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, cable_diag_pkg::IDX_RESULT_CTRL, 32'h1);
    apb(1'b1, cable_diag_pkg::IDX_RESULT_STAT, 32'h4);
    pulse(1'b0, 1'b1);
    apb(1'b0, cable_diag_pkg::IDX_TX_LOC_1_2, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, cable_diag_pkg::IDX_RESULT_STAT, 32'h0);
    chk(rd, 32'h2);
    pulse(1'b1, 1'b0);
    chk(DIAG_DONE, 1'b0);
    // Load and start in one cycle: the load wins
    pulse(1'b1, 1'b1);
    chk(DIAG_DONE, 1'b1);
    RESETN <= 1'b0;
    @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    chk(DIAG_DONE, 1'b0);
    apb(1'b0, cable_diag_pkg::IDX_RX_LOC_4_5, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule
